// ---- dmrc_ctrl.sv ----
// mode, reset and serial framing control of a half-bridge driver
// assumes analog comparators for the logic supply thresholds, host drives en and the serial bus
//
// Functional notes
// RULE_01 - logic supply power-on clears state, outputs off
// RULE_02 - load supply dropout keeps stored configuration
// RULE_03 - enable high: normal mode, pump on
// RULE_04 - enable low: sleep, outputs off, registers reset
// RULE_05 - sleep reached within 8 us of fall
// RULE_06 - supply below off threshold: interface silent, cleared
// RULE_07 - supply valid again: reset flag reads 0
// RULE_08 - after enable reset, flag reads 0
// RULE_09 - host keeps sclk low around select edges
// RULE_10 - host keeps select high 5 us between frames
// RULE_11 - sdo floats while select high, 75 ns switching
// RULE_12 - host rewrites configuration after seeing flag 0
`timescale 1ns/1ps
module dmrc_ctrl
  import dmrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en_pin,
  input  wire logic        vdd_above_on,
  input  wire logic        vdd_above_off,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo_o,
  output logic             sdo_oe,
  output logic             charge_pump_en,
  output logic             bridge_enable,
  output logic [15:0]      bridge_cfg,
  output logic             reset_seen_flag_n,
  output dmrc_mode_e       mode
);

  initial begin
    if (SDO_SWITCH_CYC < 4) $error("dmrc_ctrl: clock too slow for sdo switching time");
  end

  // ----------------------------------------------------------------
  // pin synchronisers (core domain)
  // ----------------------------------------------------------------
  dmrc_pins_s pins_raw;
  dmrc_pins_s pins_s;
  logic [3:0] pins_q;

  assign pins_raw = '{en: en_pin, vdd_above_on: vdd_above_on,
                      vdd_above_off: vdd_above_off, cs_n: cs_n};

  dmrc_sync #(.W(4)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins_q)
  );

  assign pins_s = dmrc_pins_s'(pins_q);

  // ----------------------------------------------------------------
  // link domain: shift register on sclk
  // ----------------------------------------------------------------
  dmrc_core_s r;
  dmrc_core_s r_nxt;
  dmrc_link_s lk_r;
  dmrc_link_s lk_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic       link_rst_s;

  dmrc_sync #(.W(1)) u_rst_sync (
    .clk (sclk),
    .rst (1'b0),
    .d   (r.link_rst),
    .q   (link_rst_s)
  );

  // frames are whole 16-bit words; the next status word is loaded on the
  // last edge of a frame, ready for the next one
  always_comb begin
    lk_nxt      = lk_r;
    lk_nxt.rx   = {lk_r.rx[14:0], sdi};
    bit_cnt_nxt = bit_cnt_r + 4'h1;
    if (bit_cnt_r == BIT_CNT_LAST) begin
      lk_nxt.tx = r.status;
    end else begin
      lk_nxt.tx = {lk_r.tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge sclk) begin
    if (link_rst_s) begin
      lk_r <= '{rx: WORD_RST, tx: WORD_RST};
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // select high clears the bit count while sclk is idle, so every frame
  // starts on bit 0 whatever length the one before it had
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= BIT_CNT_RST;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  assign sdo_o = lk_r.tx[FRAME_BITS-1];

  // ----------------------------------------------------------------
  // core domain: mode and reset control
  // ----------------------------------------------------------------
  logic frame_end;

  // sclk stays low around select edges, so rx is still when select rises
  assign frame_end = pins_s.cs_n && !r.cs_n_d; // RULE_09

  always_comb begin
    r_nxt        = r;
    r_nxt.cs_n_d = pins_s.cs_n;
    // hysteresis between the two supply thresholds
    r_nxt.vdd_ok = r.vdd_ok ? pins_s.vdd_above_off : pins_s.vdd_above_on;

    unique case (r.mode)
      MODE_OFF: begin
        if (r.vdd_ok) begin
          r_nxt.mode              = MODE_SLEEP; // RULE_01
          r_nxt.cfg               = CFG_RST;
          r_nxt.reset_seen_flag_n = FLAG_N_RST; // RULE_07
        end
      end
      MODE_SLEEP: begin
        r_nxt.cfg = CFG_RST; // RULE_04
        if (pins_s.en) begin
          r_nxt.mode = MODE_NORMAL; // RULE_03
        end
      end
      MODE_NORMAL: begin
        if (!pins_s.en) begin
          r_nxt.mode              = MODE_SLEEP; // RULE_05
          r_nxt.cfg               = CFG_RST; // RULE_04
          r_nxt.reset_seen_flag_n = FLAG_N_RST; // RULE_08
        end else if (frame_end) begin
          // no load-supply input: stored words survive its dropouts
          if (lk_r.rx[CMD_ACK_BIT]) begin
            r_nxt.reset_seen_flag_n = 1'b1; // RULE_12
          end else begin
            r_nxt.cfg = {1'b0, lk_r.rx[14:0]}; // RULE_02
          end
        end
      end
    endcase

    if (!r.vdd_ok) begin
      r_nxt.mode              = MODE_OFF; // RULE_06
      r_nxt.cfg               = CFG_RST;
      r_nxt.reset_seen_flag_n = FLAG_N_RST;
    end

    r_nxt.status                = WORD_RST;
    r_nxt.status[STAT_FLAG_BIT] = r.reset_seen_flag_n;
    r_nxt.status[STAT_NORM_BIT] = (r.mode == MODE_NORMAL);
    r_nxt.status[STAT_VDD_BIT]  = r.vdd_ok;
    r_nxt.status[11:0]          = r.cfg[11:0];

    r_nxt.sdo_oe    = !pins_s.cs_n && r.vdd_ok && r.mode != MODE_OFF; // RULE_11
    r_nxt.bridge_en = (r_nxt.mode == MODE_NORMAL); // RULE_03
    r_nxt.pump_en   = (r_nxt.mode == MODE_NORMAL);
    r_nxt.link_rst  = (r_nxt.mode != MODE_NORMAL); // RULE_04
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{mode: MODE_OFF, vdd_ok: 1'b0, cs_n_d: 1'b1,
             reset_seen_flag_n: FLAG_N_RST, cfg: CFG_RST, status: WORD_RST,
             sdo_oe: 1'b0, bridge_en: 1'b0, pump_en: 1'b0, link_rst: 1'b1};
    end else begin
      r <= r_nxt;
    end
  end

  assign sdo_oe            = r.sdo_oe;
  assign charge_pump_en    = r.pump_en;
  assign bridge_enable     = r.bridge_en;
  assign bridge_cfg        = r.cfg;
  assign reset_seen_flag_n = r.reset_seen_flag_n;
  assign mode              = r.mode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [15:0] en_low_age;

  always_ff @(posedge clk) begin
    if (rst || pins_s.en || r.mode != MODE_NORMAL) begin
      en_low_age <= 16'h0000;
    end else begin
      en_low_age <= en_low_age + 16'h0001;
    end
  end

  chk_por_clear: assert property ($rose(r.vdd_ok) |=> r.mode == MODE_SLEEP ##1 r.cfg == CFG_RST) // RULE_01
    else $error("power-on did not clear state");
  chk_cfg_hold: assert property (r.mode == MODE_NORMAL && pins_s.en && r.vdd_ok && !frame_end
                                 |=> $stable(r.cfg)) // RULE_02
    else $error("configuration changed without a frame");
  chk_normal_on: assert property (r.mode == MODE_NORMAL && pins_s.en && r.vdd_ok
                                  |=> charge_pump_en && bridge_enable) // RULE_03
    else $error("normal mode without charge pump");
  chk_sleep_reset: assert property (r.mode == MODE_SLEEP |-> !bridge_enable ##1 r.cfg == CFG_RST) // RULE_04
    else $error("sleep left outputs or registers set");
  chk_sleep_time: assert property (en_low_age < 16'(SLEEP_ENTRY_CYC)) // RULE_05
    else $error("sleep entry too slow");
  chk_off_quiet: assert property (!r.vdd_ok |=> !sdo_oe && !bridge_enable && r.mode == MODE_OFF) // RULE_06
    else $error("interface active below supply threshold");
  chk_flag_init: assert property ($rose(r.vdd_ok) |-> ##[1:2] !reset_seen_flag_n) // RULE_07
    else $error("reset flag not cleared at power-on");
  chk_flag_en: assert property (r.mode == MODE_NORMAL && !pins_s.en && r.vdd_ok
                                |=> !reset_seen_flag_n) // RULE_08
    else $error("reset flag not cleared by enable reset");
  chk_sdo_float: assert property ($rose(pins_s.cs_n) |=> !sdo_oe [*2]) // RULE_11
    else $error("sdo still driven after select rose");
  chk_sdo_drive: assert property (pins_s.cs_n ##1 !pins_s.cs_n && r.vdd_ok && r.mode != MODE_OFF
                                  |=> sdo_oe) // RULE_11
    else $error("sdo not driven after select fell");

  cov_normal: cover property ($rose(r.mode == MODE_NORMAL));
  cov_sleep: cover property (r.mode == MODE_NORMAL ##1 r.mode == MODE_SLEEP);
  cov_frame: cover property (r.mode == MODE_NORMAL && frame_end);
  cov_ack: cover property ($rose(reset_seen_flag_n));

endmodule // dmrc_ctrl

// ---- dmrc_ctrl_tb_top.sv ----
// self-checking bench for dmrc_ctrl: frames, sleep entry and supply loss
// assumes dmrc_host_model drives the serial side
`timescale 1ns/1ps
module dmrc_ctrl_tb_top;
  import dmrc_pkg::*;
  logic        clk, rst, en_pin, vdd_on, vdd_off;
  logic        sclk, cs_n, sdi, sdo_o, sdo_oe, sdo_last, sdo_line;
  logic        pump, bridge, flag_n;
  logic [15:0] cfg;
  logic [15:0] rx;
  dmrc_mode_e  mode;
  int          fails;
  int          n_tests;
  // {flag_n, frame word, cfg after, status seen with bit 12 masked}
  logic [48:0] rows [4] = '{{1'b0, 16'h1234, 16'h1234, 16'h6000},
                           {1'b0, 16'h7fff, 16'h7fff, 16'h6000},
                           {1'b1, 16'h8000, 16'h7fff, 16'h6234},
                           {1'b1, 16'h0a5a, 16'h0a5a, 16'h6fff}};

  dmrc_ctrl u_dut (.clk(clk), .rst(rst), .en_pin(en_pin), .vdd_above_on(vdd_on),
    .vdd_above_off(vdd_off), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .charge_pump_en(pump), .bridge_enable(bridge), .bridge_cfg(cfg),
    .reset_seen_flag_n(flag_n), .mode(mode));
  dmrc_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

  // released sdo shows the inverse of its last driven value
  assign sdo_line = sdo_oe ? sdo_o : ~sdo_last;
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo_o;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_mode(input dmrc_mode_e m);
    int k;
    k = 0;
    while (mode !== m && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (mode !== m) begin
      fails++;
      final_report();
    end
  endtask

  // frame with sdo enable looked at inside and after it
  task automatic xfer(input logic [15:0] w, input logic oe);
    fork
      u_host.frame(w, rx);
      begin
        #150;
        chk(16'(sdo_oe), 16'(oe));
      end
    join
    chk(16'(sdo_oe), 16'h0);
  endtask

  initial begin
    int k;
    fails = 0;
    n_tests = 0;
    sdo_last = 1'b0;
    rst = 1'b1;
    en_pin = 1'b1;
    vdd_on = 1'b1;
    vdd_off = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk({12'h0, flag_n, sdo_oe, pump, bridge}, 16'h0);
    chk(cfg, 16'h0);
    @(posedge clk) rst <= 1'b0;
    wait_mode(MODE_NORMAL);
    chk({15'h0, flag_n}, 16'h0);
    chk({14'h0, pump, bridge}, 16'h3);
    #(SELECT_HIGH_GAP_US * 1000 + SCLK_GUARD_NS);
    xfer(16'h0000, 1'b1);
    foreach (rows[i]) begin
      xfer(rows[i][47:32], 1'b1);
      chk(cfg, rows[i][31:16]);
      chk(rx & 16'hefff, rows[i][15:0]);
      chk({15'h0, flag_n}, {15'h0, rows[i][48]});
    end
    // enable low: sleep within the entry delay, contents cleared
    @(posedge clk) en_pin <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (bridge !== 1'b0 && k < SLEEP_ENTRY_CYC);
    chk({14'h0, pump, bridge}, 16'h0);
    chk(cfg, 16'h0);
    u_host.frame(16'h0123, rx);
    chk(cfg, 16'h0);
    @(posedge clk) en_pin <= 1'b1;
    wait_mode(MODE_NORMAL);
    chk({14'h0, pump, bridge}, 16'h3);
    chk({15'h0, flag_n}, 16'h0);
    xfer(16'h0000, 1'b1);
    xfer(16'h0055, 1'b1);
    chk(cfg, 16'h0055);
    // logic supply lost: silent interface, everything off and cleared
    @(posedge clk) vdd_on <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({14'h0, pump, bridge}, 16'h3);
    @(posedge clk) vdd_off <= 1'b0;
    wait_mode(MODE_OFF);
    @(posedge clk);
    #1;
    chk({13'h0, sdo_oe, pump, bridge}, 16'h0);
    chk(cfg, 16'h0);
    xfer(16'h0077, 1'b0);
    chk(cfg, 16'h0);
    @(posedge clk) vdd_off <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(16'(mode), 16'(MODE_OFF));
    @(posedge clk) vdd_on <= 1'b1;
    wait_mode(MODE_NORMAL);
    chk({15'h0, flag_n}, 16'h0);
    chk(cfg, 16'h0);
    // reset in mid-run: everything back to the power-on values
    xfer(16'h0042, 1'b1);
    chk(cfg, 16'h0042);
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({12'h0, flag_n, sdo_oe, pump, bridge}, 16'h0);
    chk(cfg, 16'h0);
    chk(16'(mode), 16'(MODE_OFF));
    @(posedge clk) rst <= 1'b0;
    wait_mode(MODE_NORMAL);
    chk({15'h0, flag_n}, 16'h0);
    chk(cfg, 16'h0);
    final_report();
  end
endmodule // dmrc_ctrl_tb_top

// ---- dmrc_host_model.sv ----
// host side model: drives select, serial clock and data, one frame per call
// assumes sdo_line is the resolved serial data out wire
`timescale 1ns/1ps
module dmrc_host_model
  import dmrc_pkg::*;
(
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input  wire logic sdo_line
);
  // an empty select pulse at start clears the device's bit counter
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b0;
    #(SCLK_GUARD_NS);
    cs_n = 1'b1;
  end

  // 16-bit frame, msb first; sclk runs at 160 ns only inside the frame
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    #250;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      sdi = w[i];
      #80;
      r[i] = sdo_line;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #(SCLK_GUARD_NS + 125);
    cs_n = 1'b1;
    sdi  = 1'b0;
    #(SELECT_HIGH_GAP_US * 1000);
  endtask
endmodule // dmrc_host_model

// ---- dmrc_pkg.sv ----
// constants, types and state structs for the driver mode and reset control block
// assumes a 200 MHz core clock and a 16-bit serial frame on the link clock
package dmrc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ              = 200;
  localparam int SLEEP_ENTRY_DELAY_US = 8;
  localparam int SLEEP_ENTRY_CYC      = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
  localparam int SDO_SWITCH_NS        = 75;
  localparam int SDO_SWITCH_CYC       = (SDO_SWITCH_NS * CLK_MHZ) / 1000;
  localparam int SELECT_HIGH_GAP_US   = 5;
  localparam int SCLK_GUARD_NS        = 125;

  // ----------------------------------------------------------------
  // frame layout and reset values
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS     = 16;
  localparam int          CMD_ACK_BIT    = 15;
  localparam int          STAT_FLAG_BIT  = 15;
  localparam int          STAT_NORM_BIT  = 14;
  localparam int          STAT_VDD_BIT   = 13;
  localparam logic [15:0] CFG_RST        = 16'h0000;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [3:0]  BIT_CNT_LAST   = 4'hf;
  localparam logic [3:0]  BIT_CNT_RST    = 4'h0;
  localparam logic        FLAG_N_RST     = 1'b0;

  typedef enum logic [1:0] {MODE_OFF, MODE_SLEEP, MODE_NORMAL} dmrc_mode_e;

  typedef struct packed {
    logic en;
    logic vdd_above_on;
    logic vdd_above_off;
    logic cs_n;
  } dmrc_pins_s;

  typedef struct packed {
    dmrc_mode_e  mode;
    logic        vdd_ok;
    logic        cs_n_d;
    logic        reset_seen_flag_n;
    logic [15:0] cfg;
    logic [15:0] status;
    logic        sdo_oe;
    logic        bridge_en;
    logic        pump_en;
    logic        link_rst;
  } dmrc_core_s;

  typedef struct packed {
    logic [15:0] rx;
    logic [15:0] tx;
  } dmrc_link_s;

endpackage

// ---- dmrc_sync.sv ----
// two flip-flop level synchroniser, W bits wide
// assumes each bit is a slow level; multi-bit values must be quasi-static
`timescale 1ns/1ps
module dmrc_sync
  import dmrc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  initial begin
    if (W < 1) $error("dmrc_sync: W must be at least 1");
  end

  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  always_comb begin
    stage_nxt    = stage_r;
    stage_nxt[0] = d;
    stage_nxt[1] = stage_r[0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign q = stage_r[1];

endmodule // dmrc_sync
